// *** logic/pfgmux_map.vh ***
// Register offsets, reset values and mode codes for the port F/G pin block
`ifndef PFGMUX_MAP_VH
`define PFGMUX_MAP_VH

// Register offsets, low 16 address bits
`define PFGMUX_OFS_PF_DIR 16'hFE3E
`define PFGMUX_OFS_PF_LAT 16'hFF0E
`define PFGMUX_OFS_PF_PIN 16'hFFBE
`define PFGMUX_OFS_PG_DIR 16'hFE3F
`define PFGMUX_OFS_PG_LAT 16'hFF0F
`define PFGMUX_OFS_PG_PIN 16'hFFBF

// Reset values
`define PFGMUX_RST_PF_DIR_BUS 8'h80
`define PFGMUX_RST_PF_DIR_SC 8'h00
`define PFGMUX_RST_PF_LAT 8'h00
`define PFGMUX_RST_PG_DIR_G4 5'h10
`define PFGMUX_RST_PG_DIR 5'h00
`define PFGMUX_RST_PG_LAT 5'h00

// Read values of write-only, reserved and unmapped locations
`define PFGMUX_RD_UNDEF 8'hFF
`define PFGMUX_RD_RSVD 3'h7
`define PFGMUX_RD_UNMAPPED 8'h00

// Operating modes
`define PFGMUX_MODE_4 3'h4
`define PFGMUX_MODE_5 3'h5
`define PFGMUX_MODE_6 3'h6
`define PFGMUX_MODE_7 3'h7

`endif

// *** logic/pfgmux_top.v ***
// Port F and port G registers and pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pfgmux_map.vh"

module pfgmux_top (
    // Clock, reset, clock enable
    input wire mclk,
    input wire rst_n,
    input wire ce,
    // Register port
    input wire [15:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    // Straps and standby, from pins
    input wire [2:0] mode,
    input wire bus16,
    input wire hw_standby_n,
    // Standby and pin function control, from chip logic
    input wire sw_standby,
    input wire standby_output_hold,
    input wire wait_pin_enable,
    input wire bus_release_enable,
    input wire tone_output_enable,
    // Alternate output sources from chip logic
    input wire system_clock_level,
    input wire tone_level,
    input wire address_strobe_n,
    input wire read_strobe_n,
    input wire high_byte_write_strobe_n,
    input wire low_byte_write_strobe_n,
    input wire bus_ack_n,
    input wire [3:0] chip_select_n,
    // Alternate inputs toward chip logic
    output wire wait_in_n,
    output wire bus_request_in_n,
    output wire ext_interrupt_2_n,
    output wire ext_interrupt_3_n,
    output wire ext_interrupt_6_n,
    output wire ext_interrupt_7_n,
    // Port F pins
    input wire [7:0] pf_pin_in,
    output wire [7:0] pf_pin_out,
    output wire [7:0] pf_pin_oe,
    // Port G pins
    input wire [4:0] pg_pin_in,
    output wire [4:0] pg_pin_out,
    output wire [4:0] pg_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pin-state view: output bits show the latch, input bits the pin
    function [7:0] pin_view;
        input [7:0] dir;
        input [7:0] lat;
        input [7:0] pin;
        begin
            pin_view = (dir & lat) | (~dir & pin);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pin-side inputs

    reg [7:0] pf_meta_r;
    reg [7:0] pf_sync_r;
    reg [4:0] pg_meta_r;
    reg [4:0] pg_sync_r;
    reg [2:0] mode_meta_r;
    reg [2:0] mode_sync_r;
    reg bus16_meta_r;
    reg bus16_sync_r;
    reg hws_meta_n_r;
    reg hws_sync_n_r;

    // Not reset, so straps settle while reset is still held
    always @(posedge mclk) begin
        if (ce) begin
            pf_meta_r <= pf_pin_in;
            pf_sync_r <= pf_meta_r;
            pg_meta_r <= pg_pin_in;
            pg_sync_r <= pg_meta_r;
            mode_meta_r <= mode;
            mode_sync_r <= mode_meta_r;
            bus16_meta_r <= bus16;
            bus16_sync_r <= bus16_meta_r;
            hws_meta_n_r <= hw_standby_n;
            hws_sync_n_r <= hws_meta_n_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    wire init_now;
    wire bus_mode;
    wire mode_45;
    wire bus_16bit;

    // Power-on reset and hardware standby initialise alike
    assign init_now = ~rst_n | ~hws_sync_n_r;
    assign bus_mode = (mode_sync_r == `PFGMUX_MODE_4) |
                      (mode_sync_r == `PFGMUX_MODE_5) |
                      (mode_sync_r == `PFGMUX_MODE_6);
    assign mode_45 = (mode_sync_r == `PFGMUX_MODE_4) |
                     (mode_sync_r == `PFGMUX_MODE_5);
    assign bus_16bit = bus_mode & bus16_sync_r;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg [7:0] pf_dir_r;
    reg [7:0] pf_lat_r;
    reg [4:0] pg_dir_r;
    reg [4:0] pg_lat_r;
    reg [7:0] pf_view_r;
    reg [4:0] pg_view_r;
    reg [7:0] rdata_r;
    reg [7:0] rdata_nxt;

    wire hit_pf_dir;
    wire hit_pf_lat;
    wire hit_pf_pin;
    wire hit_pg_dir;
    wire hit_pg_lat;
    wire hit_pg_pin;

    assign hit_pf_dir = (reg_addr == `PFGMUX_OFS_PF_DIR);
    assign hit_pf_lat = (reg_addr == `PFGMUX_OFS_PF_LAT);
    assign hit_pf_pin = (reg_addr == `PFGMUX_OFS_PF_PIN);
    assign hit_pg_dir = (reg_addr == `PFGMUX_OFS_PG_DIR);
    assign hit_pg_lat = (reg_addr == `PFGMUX_OFS_PG_LAT);
    assign hit_pg_pin = (reg_addr == `PFGMUX_OFS_PG_PIN);

    // Manual reset and software standby do not touch these registers
    always @(posedge mclk) begin
        if (ce) begin
            if (init_now) begin
                pf_dir_r <= bus_mode ? `PFGMUX_RST_PF_DIR_BUS
                                     : `PFGMUX_RST_PF_DIR_SC;
                pf_lat_r <= `PFGMUX_RST_PF_LAT;
                pg_dir_r <= mode_45 ? `PFGMUX_RST_PG_DIR_G4
                                    : `PFGMUX_RST_PG_DIR;
                pg_lat_r <= `PFGMUX_RST_PG_LAT;
            end else if (reg_wr) begin
                if (hit_pf_dir) begin
                    pf_dir_r <= reg_wdata;
                end
                if (hit_pf_lat) begin
                    pf_lat_r <= reg_wdata;
                end
                if (hit_pg_dir) begin
                    pg_dir_r <= reg_wdata[4:0];
                end
                if (hit_pg_lat) begin
                    pg_lat_r <= reg_wdata[4:0];
                end
            end
        end
    end

    // Port G keeps only the low five bits of the byte-wide view
    wire [7:0] pg_view_full;
    assign pg_view_full = pin_view({3'h0, pg_dir_r}, {3'h0, pg_lat_r},
                                   {3'h0, pg_sync_r});

    // Pin-state view frozen during software standby
    always @(posedge mclk) begin
        if (ce) begin
            if (init_now | ~sw_standby) begin
                pf_view_r <= pin_view(pf_dir_r, pf_lat_r, pf_sync_r);
                pg_view_r <= pg_view_full[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read

    // Pin-state registers are read-only: writes to them are dropped
    always @* begin
        rdata_nxt = `PFGMUX_RD_UNMAPPED;
        if (hit_pf_dir) begin
            rdata_nxt = `PFGMUX_RD_UNDEF;
        end else if (hit_pf_lat) begin
            rdata_nxt = pf_lat_r;
        end else if (hit_pf_pin) begin
            rdata_nxt = pf_view_r;
        end else if (hit_pg_dir) begin
            rdata_nxt = `PFGMUX_RD_UNDEF;
        end else if (hit_pg_lat) begin
            rdata_nxt = {`PFGMUX_RD_RSVD, pg_lat_r};
        end else if (hit_pg_pin) begin
            rdata_nxt = {`PFGMUX_RD_RSVD, pg_view_r};
        end
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge mclk) begin
        if (ce) begin
            if (~rst_n) begin
                rdata_r <= 8'h00;
            end else if (reg_rd) begin
                rdata_r <= rdata_nxt;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin function multiplexer

    reg [7:0] pf_out_nxt;
    reg [7:0] pf_oe_nxt;
    reg [7:0] pf_busctl;
    reg [4:0] pg_out_nxt;
    reg [4:0] pg_oe_nxt;
    reg [4:0] pg_busctl;
    reg [7:0] pf_out_r;
    reg [7:0] pf_oe_r;
    reg [4:0] pg_out_r;
    reg [4:0] pg_oe_r;

    wire bus_hiz;

    // Bus control outputs float in software standby unless held
    assign bus_hiz = sw_standby & ~standby_output_hold;

    // Latch is only read here, so it keeps its value under alternates
    always @* begin
        pf_out_nxt = pf_lat_r;
        pf_oe_nxt = pf_dir_r;
        pf_busctl = 8'h00;
        // F7: system clock out when output
        pf_out_nxt[7] = pf_dir_r[7] ? system_clock_level : 1'b0;
        // F6..F4: forced strobes in external bus modes
        if (bus_mode) begin
            pf_out_nxt[6] = address_strobe_n;
            pf_out_nxt[5] = read_strobe_n;
            pf_out_nxt[4] = high_byte_write_strobe_n;
            pf_oe_nxt[6:4] = 3'h7;
            pf_busctl[6:4] = 3'h7;
        end
        // F3: low write strobe on a 16-bit bus
        if (bus_16bit) begin
            pf_out_nxt[3] = low_byte_write_strobe_n;
            pf_oe_nxt[3] = 1'b1;
            pf_busctl[3] = 1'b1;
        end
        // F2: wait input when enabled
        if (bus_mode & wait_pin_enable) begin
            pf_oe_nxt[2] = 1'b0;
        end
        // F1: bus acknowledge, else tone, else port
        if (bus_mode & bus_release_enable) begin
            pf_out_nxt[1] = bus_ack_n;
            pf_oe_nxt[1] = 1'b1;
            pf_busctl[1] = 1'b1;
        end else if (tone_output_enable) begin
            pf_out_nxt[1] = tone_level;
            pf_oe_nxt[1] = 1'b1;
        end
        // F0: bus request input when release enabled
        if (bus_mode & bus_release_enable) begin
            pf_oe_nxt[0] = 1'b0;
        end
        if (bus_hiz) begin
            pf_oe_nxt = pf_oe_nxt & ~pf_busctl;
        end
    end

    always @* begin
        pg_out_nxt = pg_lat_r;
        pg_oe_nxt = pg_dir_r;
        pg_busctl = 5'h00;
        // G4..G1 carry chip selects 0..3 in external bus modes when set as outputs
        if (bus_mode) begin
            pg_out_nxt[4] = chip_select_n[0];
            pg_out_nxt[3] = chip_select_n[1];
            pg_out_nxt[2] = chip_select_n[2];
            pg_out_nxt[1] = chip_select_n[3];
            pg_busctl[4:1] = pg_dir_r[4:1];
        end
        if (bus_hiz) begin
            pg_oe_nxt = pg_oe_nxt & ~pg_busctl;
        end
    end

    // Registered pin drive; output enables are off while rst_n is low, not in hardware standby
    always @(posedge mclk) begin
        if (ce) begin
            if (~rst_n) begin
                pf_out_r <= 8'h00;
                pf_oe_r <= 8'h00;
                pg_out_r <= 5'h00;
                pg_oe_r <= 5'h00;
            end else begin
                pf_out_r <= pf_out_nxt;
                pf_oe_r <= pf_oe_nxt;
                pg_out_r <= pg_out_nxt;
                pg_oe_r <= pg_oe_nxt;
            end
        end
    end

    assign pf_pin_out = pf_out_r;
    assign pf_pin_oe = pf_oe_r;
    assign pg_pin_out = pg_out_r;
    assign pg_pin_oe = pg_oe_r;

    ////////////////////////////////////////////////////////////////////////
    // Alternate inputs toward chip logic

    reg wait_r;
    reg bus_req_r;
    reg ext_int2_r;
    reg ext_int3_r;
    reg ext_int6_r;
    reg ext_int7_r;

    // Inactive (high) whenever the pin is not in that function, except ext_interrupt_7_n, which follows G1 also while it carries chip select 3;
    // the pin still reads as a port bit, so software must not share it
    always @(posedge mclk) begin
        if (ce) begin
            if (~rst_n) begin
                wait_r <= 1'b1;
                bus_req_r <= 1'b1;
                ext_int2_r <= 1'b1;
                ext_int3_r <= 1'b1;
                ext_int6_r <= 1'b1;
                ext_int7_r <= 1'b1;
            end else begin
                wait_r <= (bus_mode & wait_pin_enable) ? pf_sync_r[2]
                                                       : 1'b1;
                bus_req_r <= (bus_mode & bus_release_enable) ? pf_sync_r[0]
                                                             : 1'b1;
                ext_int2_r <= (bus_mode & bus_release_enable) ? 1'b1
                                                              : pf_sync_r[0];
                ext_int3_r <= bus_16bit ? 1'b1 : pf_sync_r[3];
                ext_int6_r <= pg_sync_r[0];
                ext_int7_r <= pg_sync_r[1];
            end
        end
    end

    assign wait_in_n = wait_r;
    assign bus_request_in_n = bus_req_r;
    assign ext_interrupt_2_n = ext_int2_r;
    assign ext_interrupt_3_n = ext_int3_r;
    assign ext_interrupt_6_n = ext_int6_r;
    assign ext_interrupt_7_n = ext_int7_r;

endmodule // pfgmux_top

`default_nettype wire

// *** test/pfgmux_sva.sv ***
// Checker of the port F and port G pin block
`timescale 1ns/1ps
`default_nettype none
module pfgmux_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Straps and controls
    input wire logic [2:0] mode,
    input wire logic bus16,
    input wire logic hw_standby_n,
    input wire logic sw_standby,
    input wire logic standby_output_hold,
    input wire logic wait_pin_enable,
    input wire logic bus_release_enable,
    // Alternate sources and port F pins
    input wire logic system_clock_level,
    input wire logic bus_ack_n,
    input wire logic low_byte_write_strobe_n,
    input wire logic [7:0] pf_pin_out,
    input wire logic [7:0] pf_pin_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Straps pass two sync flops, so conditions are held five cycles
    wire logic bm = mode >= 3'h4 && mode <= 3'h6 && hw_standby_n;
    wire logic run = bm && !sw_standby;
    //////////////////////////////
    property p_pf_dir;
        $past(reg_rd) && $past(reg_addr) == 16'hFE3E |-> reg_rdata == 8'hFF;
    endproperty
    a_pf_dir: assert property (p_pf_dir)
        else $error("port F direction read not all ones");
    property p_pg_dir;
        $past(reg_rd) && $past(reg_addr) == 16'hFE3F |-> reg_rdata == 8'hFF;
    endproperty
    a_pg_dir: assert property (p_pg_dir)
        else $error("port G direction read not all ones");
    property p_pg_rsvd;
        $past(reg_rd) && $past(reg_addr[15:4]) == 12'hFFB
            && $past(reg_addr[3:0]) == 4'hF |-> reg_rdata[7:5] == 3'h7;
    endproperty
    a_pg_rsvd: assert property (p_pg_rsvd)
        else $error("port G reserved bits not ones");
    property p_strobes;
        run [*5] |-> pf_pin_oe[6:4] == 3'h7;
    endproperty
    a_strobes: assert property (p_strobes)
        else $error("bus strobes not driven");
    property p_clk;
        pf_pin_oe[7] |-> pf_pin_out[7] == $past(system_clock_level);
    endproperty
    a_clk: assert property (p_clk)
        else $error("system clock not on bit 7");
    property p_lwr;
        (run && bus16) [*5] |-> pf_pin_oe[3]
            && pf_pin_out[3] == $past(low_byte_write_strobe_n);
    endproperty
    a_lwr: assert property (p_lwr)
        else $error("low write strobe not on bit 3");
    property p_ack;
        (run && bus_release_enable) [*5] |-> pf_pin_oe[1]
            && pf_pin_out[1] == $past(bus_ack_n);
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus acknowledge not on bit 1");
    property p_bus_req;
        (bm && bus_release_enable) [*5] |-> !pf_pin_oe[0];
    endproperty
    a_bus_req: assert property (p_bus_req)
        else $error("bus request pin driven");
    property p_wait;
        (bm && wait_pin_enable) [*5] |-> !pf_pin_oe[2];
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait pin driven");
    property p_hold;
        (bm && sw_standby && !standby_output_hold) [*5]
            |-> pf_pin_oe[6:4] == 3'h0;
    endproperty
    a_hold: assert property (p_hold)
        else $error("bus strobes driven in standby");
endmodule // pfgmux_sva
bind pfgmux_top pfgmux_sva pfgmux_sva_inst (.mclk, .rst_n, .reg_addr,
    .reg_rd, .reg_rdata, .mode, .bus16, .hw_standby_n, .sw_standby,
    .standby_output_hold, .wait_pin_enable, .bus_release_enable,
    .system_clock_level, .bus_ack_n, .low_byte_write_strobe_n,
    .pf_pin_out, .pf_pin_oe);
`default_nettype wire

// *** test/pfgmux_pins.sv ***
// Board model: external drivers on port F and port G pins
`timescale 1ns/1ps
`default_nettype none
module pfgmux_pins (
    // Device side
    input wire logic [7:0] pf_pin_out,
    input wire logic [7:0] pf_pin_oe,
    input wire logic [4:0] pg_pin_out,
    input wire logic [4:0] pg_pin_oe,
    // Board drivers
    input wire logic [7:0] pf_ext,
    input wire logic [4:0] pg_ext,
    // Levels seen by the device
    output logic [7:0] pf_pin_in,
    output logic [4:0] pg_pin_in
);
    // The device wins where it drives; the board only fills released pins
    assign pf_pin_in = (pf_pin_out & pf_pin_oe) | (pf_ext & ~pf_pin_oe);
    assign pg_pin_in = (pg_pin_out & pg_pin_oe) | (pg_ext & ~pg_pin_oe);
endmodule // pfgmux_pins
`default_nettype wire

// *** test/pfgmux_top_tb.sv ***
// Testbench of the port F and port G pin block
`timescale 1ns/1ps
`default_nettype none
module pfgmux_top_tb;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, hw_standby_n = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, bus16 = 1'b0, sw_standby = 1'b0;
    logic standby_output_hold = 1'b0, wait_pin_enable = 1'b0;
    logic bus_release_enable = 1'b0, tone_output_enable = 1'b0;
    logic system_clock_level = 1'b0, tone_level = 1'b0, bus_ack_n = 1'b1;
    logic address_strobe_n = 1'b1, read_strobe_n = 1'b1;
    logic high_byte_write_strobe_n = 1'b1, low_byte_write_strobe_n = 1'b1;
    logic [3:0] chip_select_n = 4'hF, cs_prev = 4'hF;
    logic tone_prev = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, pf_ext = 8'h00;
    logic [2:0] mode = 3'h4;
    logic [4:0] pg_ext = 5'h00;
    logic [31:0] cyc = 32'h0000_0000;
    wire logic [7:0] reg_rdata, pf_pin_in, pf_pin_out, pf_pin_oe;
    wire logic [4:0] pg_pin_in, pg_pin_out, pg_pin_oe;
    wire logic wait_in_n, bus_request_in_n, ext_interrupt_2_n;
    wire logic ext_interrupt_3_n, ext_interrupt_6_n, ext_interrupt_7_n;
    int errors = 0, cmp_count = 0;
    pfgmux_top pfgmux_top_inst (.mclk, .rst_n, .ce, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .mode, .bus16, .hw_standby_n,
        .sw_standby, .standby_output_hold, .wait_pin_enable,
        .bus_release_enable, .tone_output_enable, .system_clock_level,
        .tone_level, .address_strobe_n, .read_strobe_n,
        .high_byte_write_strobe_n, .low_byte_write_strobe_n, .bus_ack_n,
        .chip_select_n, .wait_in_n, .bus_request_in_n, .ext_interrupt_2_n,
        .ext_interrupt_3_n, .ext_interrupt_6_n, .ext_interrupt_7_n,
        .pf_pin_in, .pf_pin_out, .pf_pin_oe, .pg_pin_in, .pg_pin_out,
        .pg_pin_oe);
    pfgmux_pins pfgmux_pins_inst (.pf_pin_out, .pf_pin_oe, .pg_pin_out,
        .pg_pin_oe, .pf_ext, .pg_ext, .pf_pin_in, .pg_pin_in);
    //////////////////////////////
    always #2.5 mclk = ~mclk;
    // Bus controller sources keep moving so stuck pins show
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        cs_prev <= chip_select_n;
        tone_prev <= tone_level;
        {address_strobe_n, read_strobe_n, high_byte_write_strobe_n,
            low_byte_write_strobe_n, bus_ack_n, chip_select_n,
            system_clock_level, tone_level} <= cyc[10:0];
        if (cyc == 5000) begin
            errors++;
            report_and_stop;
        end
    end
    task automatic chk(input string n, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input string n, input logic [15:0] a, logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(n, reg_rdata, e);
    endtask
    // Pin view is two sync flops and a view flop deep
    task automatic st;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic init_mode(input logic [2:0] m);
        @(posedge mclk);
        mode <= m;
        hw_standby_n <= 1'b0;
        repeat (4) @(posedge mclk);
        hw_standby_n <= 1'b1;
        st;
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    //////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        st;
        chk("pf_oe", pf_pin_oe, 8'hF0);
        chk("pg_oe", {3'h0, pg_pin_oe}, 8'h10);
        $display("Test reset defaults done");
        // Latches are dirtied each round so the next init must clear them
        for (int m = 4; m < 8; m++) begin
            init_mode(3'(m));
            chk("pf_oe", pf_pin_oe, m < 7 ? 8'hF0 : 8'h00);
            chk("pg_oe", {3'h0, pg_pin_oe}, m < 6 ? 8'h10 : 8'h00);
            rc("pf_lat", 16'hFF0E, 8'h00);
            rc("pg_lat", 16'hFF0F, 8'hE0);
            rc("pf_dir", 16'hFE3E, 8'hFF);
            rc("pg_dir", 16'hFE3F, 8'hFF);
            rc("unmapped", 16'hFF10, 8'h00);
            wr(16'hFF0E, 8'h5A);
            wr(16'hFF0F, 8'h13);
            $display("Test init mode %0d done", m);
        end
        wr(16'hFE3E, 8'h0F);
        wr(16'hFE3F, 8'h05);
        pf_ext <= 8'hC3;
        pg_ext <= 5'h0A;
        st;
        chk("pf_oe", pf_pin_oe, 8'h0F);
        chk("pf_out", pf_pin_out & 8'h0F, 8'h0A);
        chk("pg_oe", {3'h0, pg_pin_oe}, 8'h05);
        rc("pf_pin", 16'hFFBE, 8'hCA);
        wr(16'hFFBE, 8'hFF);
        rc("pf_pin", 16'hFFBE, 8'hCA);
        rc("pg_pin", 16'hFFBF, 8'hEB);
        // Tone source toggles, so two looks catch a stuck latch bit
        @(posedge mclk);
        tone_output_enable <= 1'b1;
        st;
        chk("tone", {7'h0, pf_pin_out[1]}, {7'h0, tone_prev});
        @(posedge mclk);
        #1 chk("tone", {7'h0, pf_pin_out[1]}, {7'h0, tone_prev});
        @(posedge mclk);
        tone_output_enable <= 1'b0;
        sw_standby <= 1'b1;
        pf_ext <= 8'h3C;
        st;
        rc("pf_hold", 16'hFFBE, 8'hCA);
        @(posedge mclk);
        sw_standby <= 1'b0;
        st;
        chk("pg_oe", {3'h0, pg_pin_oe}, 8'h05);
        rc("pf_pin", 16'hFFBE, 8'h3A);
        // A write while the clock enable is low must be lost
        @(posedge mclk);
        ce <= 1'b0;
        wr(16'hFF0E, 8'hA5);
        ce <= 1'b1;
        rc("ce_hold", 16'hFF0E, 8'h5A);
        $display("Test mode 7 ports done");
        init_mode(3'h4);
        wr(16'hFE3E, 8'h87);
        wr(16'hFF0E, 8'h07);
        bus16 <= 1'b1;
        wait_pin_enable <= 1'b1;
        bus_release_enable <= 1'b1;
        pf_ext <= 8'h00;
        st;
        chk("pf_oe", pf_pin_oe, 8'hFA);
        chk("alt", {4'h0, wait_in_n, bus_request_in_n, ext_interrupt_2_n,
            ext_interrupt_3_n}, 8'h03);
        // Interrupt pins are left as inputs only
        wr(16'hFE3E, 8'h80);
        bus16 <= 1'b0;
        wait_pin_enable <= 1'b0;
        bus_release_enable <= 1'b0;
        pf_ext <= 8'h0A;
        st;
        chk("irq", {4'h0, wait_in_n, bus_request_in_n, ext_interrupt_2_n,
            ext_interrupt_3_n}, 8'h0D);
        chk("irq67", {6'h0, ext_interrupt_7_n, ext_interrupt_6_n},
            8'h02);
        wr(16'hFF0F, 8'h15);
        wr(16'hFE3F, 8'h1E);
        st;
        chk("pg_oe", {3'h0, pg_pin_oe}, 8'h1E);
        chk("cs", {4'h0, pg_pin_out[4:1]}, {4'h0, cs_prev[0], cs_prev[1],
            cs_prev[2], cs_prev[3]});
        @(posedge mclk);
        sw_standby <= 1'b1;
        st;
        chk("pg_oe", {3'h0, pg_pin_oe}, 8'h00);
        @(posedge mclk);
        standby_output_hold <= 1'b1;
        st;
        chk("pg_oe", {3'h0, pg_pin_oe}, 8'h1E);
        @(posedge mclk);
        sw_standby <= 1'b0;
        rc("pg_lat", 16'hFF0F, 8'hF5);
        rc("pf_lat", 16'hFF0E, 8'h07);
        $display("Test bus mode functions done");
        report_and_stop;
    end
endmodule // pfgmux_top_tb
`default_nettype wire
